// ---- cbt_pkg.sv ----
// Constants, carriers and state type for the CAN bit timing block
package cbt_pkg;

  // ==========================================================
  // Register window (byte offsets inside the 128-byte window)
  localparam logic [6:0] OFS_CTL_A   = 7'h00;
  localparam logic [6:0] OFS_CTL_B   = 7'h01;
  localparam logic [6:0] OFS_BTR_A   = 7'h02;
  localparam logic [6:0] OFS_BTR_B   = 7'h03;
  localparam logic [6:0] OFS_STATUS  = 7'h04;
  localparam logic [6:0] OFS_RX_ERR  = 7'h0E;
  localparam logic [6:0] OFS_TX_ERR  = 7'h0F;
  localparam logic [2:0] FILT_HI     = 3'h2;
  localparam logic [1:0] BUF_RX_SLOT = 2'h0;
  localparam logic [3:0] SLOT_LAST   = 4'hC;
  localparam logic [3:0] SLOT_PRIO   = 4'hD;

  // ==========================================================
  // Field positions and write masks
  localparam int LOCK_BIT   = 0;
  localparam int CLKSEL_BIT = 0;
  localparam int WAKE_BIT   = 1;
  localparam int LOOP_BIT   = 2;
  localparam int JUMP_LSB   = 6;
  localparam int BRP_MSB    = 5;
  localparam int SEG1_MSB   = 3;
  localparam int SEG2_LSB   = 4;
  localparam int SEG2_MSB   = 6;
  localparam int SAMP3_BIT  = 7;
  localparam logic [7:0] CTL_A_WMASK = 8'h0B;
  localparam logic [7:0] CTL_B_WMASK = 8'h07;

  // ==========================================================
  // Reset values
  localparam logic [7:0] CTL_A_RST = 8'h01;
  localparam logic [7:0] CTL_B_RST = 8'h00;
  localparam logic [7:0] BTR_A_RST = 8'h00;
  localparam logic [7:0] BTR_B_RST = 8'h00;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [6:0] addr;
    logic [7:0] wdata;
  } cbt_cpu_req_t;

  typedef struct packed {
    logic       we;
    logic [3:0] idx;
    logic [7:0] data;
  } cbt_rxbuf_wr_t;

  typedef struct packed {
    logic [1:0] sel;
    logic [3:0] idx;
  } cbt_txbuf_rd_t;

  // ==========================================================
  // Bit segment state machine
  typedef enum logic [2:0] {
    SEG_SYNC = 3'b001,
    SEG_ONE  = 3'b010,
    SEG_TWO  = 3'b100
  } cbt_seg_t;

  typedef struct packed {
    logic [7:0]       ctl_a;
    logic [7:0]       ctl_b;
    logic [7:0]       btr_a;
    logic [7:0]       btr_b;
    logic [7:0][7:0]  filt;
    logic [63:0][7:0] mbuf;
    logic [7:0]       rdata;
    logic [7:0]       txb_rdata;
    logic [5:0]       presc;
    cbt_seg_t         seg;
    logic [4:0]       cnt;
    logic [2:0]       ext;
    logic [2:0]       shr;
    logic [2:0]       rx_sync;
    logic             rx_filt;
    logic             edge_pend;
    logic [1:0]       samp_hist;
    logic             rx_bit;
    logic             rx_valid;
    logic             tx_pin;
    logic             bit_start;
  } cbt_state_t;

endpackage : cbt_pkg

// ---- cbt_bit_timing.sv ----
// CAN bit timing generator, register window and transmit bit FIFO

// ============================================================
// Transmit bit FIFO
module cbt_fifo #(
  parameter int W = 1,
  parameter int D = 8
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         reset,
  // Fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // Drain side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       rd;
    logic [AW-1:0]       wr;
    logic [CW-1:0]       cnt;
  } cbt_fifo_st_t;

  cbt_fifo_st_t q;
  cbt_fifo_st_t next_q;
  logic         push;
  logic         pop;

  assign in_ready  = q.cnt != CW'(D);
  assign out_valid = q.cnt != '0;
  assign out_data  = q.mem[q.rd];

  always_comb
  begin
    next_q = q;
    push   = in_valid && in_ready;
    pop    = out_valid && out_ready;
    if (push)
    begin
      next_q.mem[q.wr] = in_data;
      next_q.wr = (q.wr == AW'(D - 1)) ? '0 : q.wr + AW'(1);
    end
    if (pop)
      next_q.rd = (q.rd == AW'(D - 1)) ? '0 : q.rd + AW'(1);
    if (push && !pop)
      next_q.cnt = q.cnt + CW'(1);
    else if (pop && !push)
      next_q.cnt = q.cnt - CW'(1);
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      q <= '0;
    else
      q <= next_q;
  end

endmodule : cbt_fifo

// ============================================================
// Top: bit timing and register window
module cbt_bit_timing #(
  parameter int TXQ_DEPTH = 8
) (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  reset,
  // Processor register port
  input  wire cbt_pkg::cbt_cpu_req_t cpu_req,
  output logic [7:0]                 cpu_rdata,
  // Protocol clock enables
  input  wire logic                  osc_en,
  input  wire logic                  pll_en,
  // CAN transceiver pins
  input  wire logic                  can_rx,
  output logic                       can_tx,
  // Transmit bit stream from frame engine
  input  wire logic                  txq_valid,
  input  wire logic                  txq_bit,
  output logic                       txq_ready,
  // Received bits to frame engine
  output logic                       rx_bit,
  output logic                       rx_bit_valid,
  output logic                       bit_start,
  // Frame engine buffer access
  input  wire cbt_pkg::cbt_rxbuf_wr_t rxbuf_wr,
  input  wire cbt_pkg::cbt_txbuf_rd_t txbuf_rd,
  output logic [7:0]                 txbuf_rdata,
  // Error counters kept by frame engine
  input  wire logic [7:0]            rx_err_cnt,
  input  wire logic [7:0]            tx_err_cnt,
  // Configuration to other blocks
  output logic                       soft_init_lock,
  output logic                       loopback_en,
  output logic                       wake_filter_en,
  output logic [63:0]                ident_filter
);
  import cbt_pkg::*;

  cbt_state_t q;
  cbt_state_t next_q;

  logic       fifo_valid;
  logic       fifo_bit;
  logic       fifo_pop;
  logic       sel_en;
  logic       tq;
  logic       falling;
  logic       edge_seen;
  logic       bit_begin;
  logic       maj;
  logic [5:0] brp;
  logic [2:0] jump_w;
  logic [4:0] seg1_len;
  logic [4:0] seg2_len;
  logic [4:0] cnt_inc;
  logic [2:0] e1;
  logic [4:0] rem2;
  logic [6:0] a;
  logic [7:0] rd_val;
  logic       lock;

  cbt_fifo #(
    .W (1),
    .D (TXQ_DEPTH)
  ) u_txq (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .in_valid  (txq_valid),
    .in_data   (txq_bit),
    .in_ready  (txq_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_bit),
    .out_ready (fifo_pop)
  );

  // ==========================================================
  // Timing fields
  assign lock     = q.ctl_a[LOCK_BIT];
  assign brp      = q.btr_a[BRP_MSB:0];
  assign jump_w   = {1'b0, q.btr_a[7:JUMP_LSB]} + 3'd1;
  assign seg1_len = {1'b0, q.btr_b[SEG1_MSB:0]} + 5'd1;
  assign seg2_len =
    {2'b00, q.btr_b[SEG2_MSB:SEG2_LSB]} + 5'd1;

  assign sel_en = q.ctl_b[CLKSEL_BIT] ? pll_en : osc_en;
  assign tq = !lock && sel_en && (q.presc == brp);

  assign a = cpu_req.addr;

  // ==========================================================
  // Read decode
  always_comb
  begin
    rd_val = 8'h00;
    if (a == OFS_CTL_A)
      rd_val = q.ctl_a;
    else if (a == OFS_CTL_B)
      rd_val = q.ctl_b;
    else if (a == OFS_BTR_A)
      rd_val = q.btr_a;
    else if (a == OFS_BTR_B)
      rd_val = q.btr_b;
    else if (a == OFS_STATUS)
      rd_val = {1'b0, q.seg, q.rx_filt, !txq_ready,
                !fifo_valid, q.rx_bit};
    else if (a == OFS_RX_ERR)
      rd_val = rx_err_cnt;
    else if (a == OFS_TX_ERR)
      rd_val = tx_err_cnt;
    else if (a[6:3] == {1'b0, FILT_HI})
      rd_val = q.filt[a[2:0]];
    else if (a[6])
    begin
      if (a[5:4] == BUF_RX_SLOT)
        rd_val = (a[3:0] <= SLOT_LAST) ? q.mbuf[a[5:0]] : 8'h00;
      else
        rd_val = (a[3:0] <= SLOT_PRIO) ? q.mbuf[a[5:0]] : 8'h00;
    end
  end

  // ==========================================================
  // Next state
  always_comb
  begin
    next_q           = q;
    next_q.rx_valid  = 1'b0;
    next_q.bit_start = 1'b0;
    bit_begin        = 1'b0;
    e1               = 3'd0;
    rem2             = 5'd0;
    cnt_inc          = q.cnt + 5'd1;
    maj              = 1'b0;

    // Bus port: reads answer one cycle later
    if (cpu_req.rd)
      next_q.rdata = rd_val;
    if (cpu_req.wr)
    begin
      if (a == OFS_CTL_A)
        next_q.ctl_a = cpu_req.wdata & CTL_A_WMASK;
      else if (lock && a == OFS_CTL_B)
        next_q.ctl_b = cpu_req.wdata & CTL_B_WMASK;
      else if (lock && a == OFS_BTR_A)
        next_q.btr_a = cpu_req.wdata;
      else if (lock && a == OFS_BTR_B)
        next_q.btr_b = cpu_req.wdata;
      else if (lock && a[6:3] == {1'b0, FILT_HI})
        next_q.filt[a[2:0]] = cpu_req.wdata;
      else if (a[6] && a[5:4] != BUF_RX_SLOT
               && a[3:0] <= SLOT_PRIO)
        next_q.mbuf[a[5:0]] = cpu_req.wdata;
      // Error counters and reserved bytes fall through
    end

    // Frame engine stores received message bytes
    if (rxbuf_wr.we && rxbuf_wr.idx <= SLOT_LAST)
      next_q.mbuf[{BUF_RX_SLOT, rxbuf_wr.idx}] = rxbuf_wr.data;

    // Frame engine reads a transmit slot
    if (txbuf_rd.sel != 2'd3)
      next_q.txb_rdata =
        q.mbuf[{txbuf_rd.sel + 2'd1, txbuf_rd.idx}];
    else
      next_q.txb_rdata = 8'h00;

    // Receive pin qualification
    next_q.rx_sync = {q.rx_sync[1:0], can_rx};
    if (q.rx_sync[1] == q.rx_sync[2])
      next_q.rx_filt = q.rx_sync[2];
    falling   = q.rx_filt && !next_q.rx_filt;
    edge_seen = q.edge_pend || falling;
    if (falling)
      next_q.edge_pend = 1'b1;

    if (lock)
    begin
      // Off-line: timing parked, bus left recessive
      next_q.presc     = 6'd0;
      next_q.seg       = SEG_SYNC;
      next_q.cnt       = 5'd0;
      next_q.ext       = 3'd0;
      next_q.shr       = 3'd0;
      next_q.tx_pin    = 1'b1;
      next_q.edge_pend = 1'b0;
    end
    else if (sel_en)
    begin
      if (tq)
        next_q.presc = 6'd0;
      else
        next_q.presc = q.presc + 6'd1;
    end

    if (tq)
    begin
      next_q.edge_pend = 1'b0;
      case (q.seg)
        SEG_SYNC:
        begin
          // One quantum only
          next_q.seg = SEG_ONE;
          next_q.cnt = 5'd0;
          next_q.ext = 3'd0;
          next_q.samp_hist = {q.samp_hist[0], q.rx_filt};
        end
        SEG_ONE:
        begin
          next_q.samp_hist = {q.samp_hist[0], q.rx_filt};
          e1 = q.ext;
          // Late edge: stretch segment one, capped
          if (edge_seen && q.ext == 3'd0)
          begin
            if (cnt_inc > {2'b00, jump_w})
              e1 = jump_w;
            else
              e1 = cnt_inc[2:0];
          end
          next_q.ext = e1;
          if (cnt_inc >= seg1_len + {2'b00, e1})
          begin
            maj = (q.samp_hist[1] & q.samp_hist[0])
                | (q.samp_hist[1] & q.rx_filt)
                | (q.samp_hist[0] & q.rx_filt);
            next_q.rx_bit =
              q.btr_b[SAMP3_BIT] ? maj : q.rx_filt;
            next_q.rx_valid = 1'b1;
            next_q.seg = SEG_TWO;
            next_q.cnt = 5'd0;
            next_q.shr = 3'd0;
          end
          else
            next_q.cnt = cnt_inc;
        end
        SEG_TWO:
        begin
          rem2 = seg2_len - q.cnt;
          if (edge_seen && rem2 <= {2'b00, jump_w})
          begin
            // Early edge close to the end: resync here
            bit_begin  = 1'b1;
            next_q.seg = SEG_ONE;
            next_q.cnt = 5'd0;
            next_q.ext = 3'd0;
          end
          else
          begin
            if (edge_seen)
              next_q.shr = jump_w;
            if (cnt_inc >= seg2_len
                - {2'b00, edge_seen ? jump_w : q.shr})
            begin
              bit_begin  = 1'b1;
              next_q.seg = SEG_SYNC;
              next_q.cnt = 5'd0;
            end
            else
              next_q.cnt = cnt_inc;
          end
        end
        default:
        begin
          next_q.seg = SEG_SYNC;
          next_q.cnt = 5'd0;
        end
      endcase
    end

    // Transmit point at the head of each bit
    fifo_pop = bit_begin && fifo_valid;
    if (bit_begin)
    begin
      next_q.bit_start = 1'b1;
      next_q.tx_pin    = fifo_valid ? fifo_bit : 1'b1;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      q         <= '0;
      q.ctl_a   <= CTL_A_RST;
      q.ctl_b   <= CTL_B_RST;
      q.btr_a   <= BTR_A_RST;
      q.btr_b   <= BTR_B_RST;
      q.seg     <= SEG_SYNC;
      q.rx_sync <= 3'b111;
      q.rx_filt <= 1'b1;
      q.tx_pin  <= 1'b1;
    end
    else
      q <= next_q;
  end

  // ==========================================================
  // Outputs
  assign cpu_rdata      = q.rdata;
  assign can_tx         = q.tx_pin;
  assign rx_bit         = q.rx_bit;
  assign rx_bit_valid   = q.rx_valid;
  assign bit_start      = q.bit_start;
  assign txbuf_rdata    = q.txb_rdata;
  assign soft_init_lock = lock;
  assign loopback_en    = q.ctl_b[LOOP_BIT];
  assign wake_filter_en = q.ctl_b[WAKE_BIT];
  assign ident_filter   = q.filt;

endmodule : cbt_bit_timing

// ---- cbt_checker.sv ----
// Port-level checks for the CAN bit timing block
module cbt_checker (
  // Clock and reset
  input wire logic                   clk_sys,
  input wire logic                   reset,
  // Register port
  input wire cbt_pkg::cbt_cpu_req_t  cpu_req,
  input wire logic [7:0]             cpu_rdata,
  // Bus and bit stream
  input wire logic                   can_tx,
  input wire logic                   bit_start,
  input wire logic                   rx_bit_valid,
  // Buffers and counters
  input wire cbt_pkg::cbt_txbuf_rd_t txbuf_rd,
  input wire logic [7:0]             txbuf_rdata,
  input wire logic [7:0]             rx_err_cnt,
  // Configuration
  input wire logic                   soft_init_lock,
  input wire logic                   loopback_en,
  input wire logic                   wake_filter_en,
  input wire logic [63:0]            ident_filter
);
  import cbt_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  // ====
  // Sequences
  sequence s_open;
    !soft_init_lock ##1 !soft_init_lock;
  endsequence
  sequence s_locked;
    soft_init_lock ##1 soft_init_lock;
  endsequence
  sequence s_rd_err;
    cpu_req.rd && cpu_req.addr == OFS_RX_ERR;
  endsequence

  // ====
  // Properties
  property p_park;
    s_locked |-> !bit_start && !rx_bit_valid && can_tx;
  endproperty
  property p_tx_hold;
    s_open ##0 !bit_start |-> $stable(can_tx);
  endproperty
  property p_err_rd;
    s_rd_err |=> cpu_rdata == $past(rx_err_cnt);
  endproperty
  property p_rsvd;
    cpu_req.rd && cpu_req.addr inside {[7'h09:7'h0D], [7'h18:7'h3F]}
      |=> cpu_rdata == 8'h00;
  endproperty
  property p_rx_prio;
    cpu_req.rd && cpu_req.addr inside {[7'h4D:7'h4F]} |=> cpu_rdata == 8'h00;
  endproperty
  property p_unused;
    cpu_req.rd && cpu_req.addr[6] && cpu_req.addr[3:1] == 3'h7
      |=> cpu_rdata == 8'h00;
  endproperty
  property p_cfg_hold;
    s_open |-> $stable({ident_filter, loopback_en, wake_filter_en});
  endproperty
  property p_sel3;
    txbuf_rd.sel == 2'h3 |=> txbuf_rdata == 8'h00;
  endproperty
  property p_samp;
    rx_bit_valid |-> !bit_start ##1 !rx_bit_valid;
  endproperty
  property p_min_bit;
    bit_start |=> !bit_start [*2];
  endproperty

  a_park: assert property (p_park) else $error("bits while locked");
  a_tx_hold: assert property (p_tx_hold) else $error("tx moved");
  a_err_rd: assert property (p_err_rd) else $error("err count");
  a_rsvd: assert property (p_rsvd) else $error("reserved read");
  a_rx_prio: assert property (p_rx_prio) else $error("rx tail");
  a_unused: assert property (p_unused) else $error("unused byte");
  a_cfg_hold: assert property (p_cfg_hold) else $error("cfg moved");
  a_sel3: assert property (p_sel3) else $error("no fourth buffer");
  a_samp: assert property (p_samp) else $error("sample point");
  a_min_bit: assert property (p_min_bit) else $error("short bit");
endmodule : cbt_checker

// ---- cbt_bus_node.sv ----
// Bus model: idle remote nodes behind a transceiver with loop delay
module cbt_bus_node #(
  parameter int DLY = 2
) (
  // Clock
  input  wire logic clk_sys,
  // Transceiver side
  input  wire logic can_tx,
  output logic      can_rx
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [DLY-1:0] pipe = '1;

  // Wired-AND bus; remote nodes stay recessive, so released reads high
  always_ff @(posedge clk_sys)
  begin
    pipe <= {pipe[DLY-2:0], can_tx};
  end
  assign can_rx = pipe[DLY-1];
endmodule : cbt_bus_node

// ---- tb.sv ----
// Self-checking bench for the CAN bit timing block
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import cbt_pkg::*;
  logic          clk_sys = 1'b0;
  logic          reset = 1'b1;
  cbt_cpu_req_t  cpu_req = '0;
  logic          pll_en = 1'b0;
  logic          txq_valid = 1'b0;
  logic          txq_bit = 1'b0;
  cbt_rxbuf_wr_t rxbuf_wr = '0;
  cbt_txbuf_rd_t txbuf_rd = '0;
  logic [7:0]    cpu_rdata, txbuf_rdata;
  logic          can_rx, can_tx, txq_ready, rx_bit, rx_bit_valid, bit_start;
  logic [63:0]   ident_filter;
  logic          soft_init_lock, loopback_en, wake_filter_en;
  logic [8:0]    pat = 9'h197;
  int            n_fail = 0;
  int            checks = 0;

  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) pll_en <= ~pll_en;

  cbt_bit_timing i_cbt_bit_timing (
    .clk_sys(clk_sys), .reset(reset), .cpu_req(cpu_req),
    .cpu_rdata(cpu_rdata), .osc_en(1'b1), .pll_en(pll_en),
    .can_rx(can_rx), .can_tx(can_tx), .txq_valid(txq_valid),
    .txq_bit(txq_bit), .txq_ready(txq_ready), .rx_bit(rx_bit),
    .rx_bit_valid(rx_bit_valid), .bit_start(bit_start),
    .rxbuf_wr(rxbuf_wr), .txbuf_rd(txbuf_rd), .txbuf_rdata(txbuf_rdata),
    .rx_err_cnt(8'hA5), .tx_err_cnt(8'h3C),
    .soft_init_lock(soft_init_lock), .loopback_en(loopback_en),
    .wake_filter_en(wake_filter_en), .ident_filter(ident_filter));
  cbt_bus_node #(.DLY(2)) i_cbt_bus_node (
    .clk_sys(clk_sys), .can_tx(can_tx), .can_rx(can_rx));

  // ====
  // Shared tasks
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    cpu_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clk_sys);
    cpu_req <= '0;
  endtask : wr
  task automatic rc(input logic [6:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    cpu_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge clk_sys);
    cpu_req <= '0;
    #1;
    chk("cpu_rdata", e, cpu_rdata);
  endtask : rc
  // Cycles to next bit start, and to the sample point before it
  task automatic nxt(output int g, output int r, input logic e);
    g = 0;
    r = 0;
    do
    begin
      @(posedge clk_sys);
      #1;
      g++;
      if (rx_bit_valid === 1'b1)
      begin
        r = g;
        chk("rx_bit", 8'(e), 8'(rx_bit));
      end
    end
    while (bit_start !== 1'b1 && g < 400);
    if (g >= 400)
      chk("bit_start", 8'h01, 8'h00);
  endtask : nxt

  // ====
  // Scenarios
  task automatic t_regs();
    rc(OFS_CTL_A, CTL_A_RST);
    chk("soft_init_lock", 8'h01, 8'(soft_init_lock));
    rc(OFS_CTL_B, CTL_B_RST);
    rc(OFS_BTR_A, BTR_A_RST);
    wr(OFS_RX_ERR, 8'h00);
    rc(OFS_RX_ERR, 8'hA5);
    rc(OFS_TX_ERR, 8'h3C);
    wr(7'h0A, 8'hFF);
    rc(7'h0A, 8'h00);
    wr(7'h3F, 8'hFF);
    rc(7'h3F, 8'h00);
    wr(7'h10, 8'h5A);
    wr(7'h17, 8'hC3);
    rc(7'h17, 8'hC3);
    chk("ident_filter", 8'h5A, ident_filter[7:0]);
  endtask : t_regs
  task automatic t_bufs();
    wr(7'h5D, 8'h11);
    wr(7'h6C, 8'h22);
    wr(7'h7F, 8'hEE);
    wr(7'h41, 8'hFF);
    rc(7'h5D, 8'h11);
    rc(7'h6C, 8'h22);
    rc(7'h7F, 8'h00);
    rc(7'h41, 8'h00);
    @(posedge clk_sys);
    rxbuf_wr <= '{we: 1'b1, idx: 4'h0, data: 8'h9A};
    txbuf_rd <= '{sel: 2'h1, idx: 4'hC};
    @(posedge clk_sys);
    rxbuf_wr <= '{we: 1'b1, idx: 4'hD, data: 8'h77};
    txbuf_rd <= '{sel: 2'h3, idx: 4'hC};
    #1;
    chk("txbuf_rdata", 8'h22, txbuf_rdata);
    @(posedge clk_sys);
    rxbuf_wr <= '0;
    txbuf_rd <= '0;
    #1;
    chk("txbuf_rdata", 8'h00, txbuf_rdata);
    rc(7'h40, 8'h9A);
    rc(7'h4D, 8'h00);
  endtask : t_bufs
  task automatic t_bits_a();
    int g, r;
    logic [9:0] sent;
    sent = {pat, 1'b1};
    wr(OFS_BTR_A, 8'h41);
    wr(OFS_BTR_B, 8'h13);
    rc(OFS_BTR_B, 8'h13);
    @(posedge clk_sys);
    txq_valid <= 1'b1;
    txq_bit <= pat[0];
    for (int i = 1; i < 8; i++)
    begin
      @(posedge clk_sys);
      txq_bit <= pat[i];
    end
    @(posedge clk_sys);
    txq_valid <= 1'b0;
    #1;
    chk("txq_ready", 8'h00, 8'(txq_ready));
    rc(OFS_STATUS, 8'h1C);
    wr(OFS_CTL_A, 8'h00);
    // Only gaps of bits that begin without a falling edge are exact; own edges resync
    for (int i = 0; i < 9; i++)
    begin
      nxt(g, r, sent[i]);
      chk("can_tx", 8'(pat[i]), 8'(can_tx));
      if (i == 1 || i == 2)
      begin
        chk("bit_len", 8'd14, 8'(g));
        chk("seg_two", 8'd4, 8'(g - r));
      end
    end
    chk("soft_init_lock", 8'h00, 8'(soft_init_lock));
  endtask : t_bits_a
  task automatic t_bits_b();
    int g, r;
    wr(OFS_CTL_A, 8'h01);
    wr(OFS_CTL_B, 8'h07);
    wr(OFS_BTR_B, 8'hFF);
    wr(OFS_CTL_A, 8'h00);
    wr(OFS_BTR_A, 8'hFF);
    wr(7'h10, 8'h00);
    wr(OFS_CTL_B, 8'h00);
    rc(OFS_BTR_A, 8'h41);
    rc(OFS_CTL_B, 8'h07);
    chk("ident_filter", 8'h5A, ident_filter[7:0]);
    chk("loopback_en", 8'h01, 8'(loopback_en));
    chk("wake_filter_en", 8'h01, 8'(wake_filter_en));
    nxt(g, r, 1'b1);
    nxt(g, r, 1'b1);
    chk("bit_len", 8'd100, 8'(g));
    chk("seg_two", 8'd32, 8'(g - r));
    chk("can_tx", 8'h01, 8'(can_tx));
  endtask : t_bits_b

  task automatic close_out();
    if (n_fail == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  initial
  begin
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    t_regs();
    t_bufs();
    t_bits_a();
    t_bits_b();
    close_out();
  end
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    n_fail++;
    close_out();
  end
endmodule : tb

bind cbt_bit_timing cbt_checker i_cbt_checker (
  .clk_sys(clk_sys), .reset(reset), .cpu_req(cpu_req),
  .cpu_rdata(cpu_rdata), .can_tx(can_tx), .bit_start(bit_start),
  .rx_bit_valid(rx_bit_valid), .txbuf_rd(txbuf_rd),
  .txbuf_rdata(txbuf_rdata), .rx_err_cnt(rx_err_cnt),
  .soft_init_lock(soft_init_lock), .loopback_en(loopback_en),
  .wake_filter_en(wake_filter_en), .ident_filter(ident_filter));
